// file: rtl/sensor_ctl_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz pclk, 32-bit APB data
// Notes: Definitions only
`ifndef SENSOR_CTL_CONSTS_SVH
`define SENSOR_CTL_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL_CFG 12'h000
`define OFS_FW_CTRL 12'h004
`define OFS_RESULT 12'h008
`define OFS_STATUS 12'h00C
`define OFS_IRQ_STAT 12'h010
`define OFS_IRQ_MASK 12'h014

// ****************************************
// Field positions
// ****************************************
// CTRL_CFG: which functions the control pin asserts
`define CFG_CAL_BIT 0
`define CFG_AZ_BIT 1
`define CFG_ST_BIT 2
// FW_CTRL: firmware requests
`define FW_CAL_EN_BIT 0
`define FW_AZ_GO_BIT 1
`define FW_ST_GO_BIT 2
`define FW_BUSY_BIT 3
`define FW_DONE_BIT 4
`define FW_FAIL_BIT 5
`define FW_TRIM_BIT 6
// RESULT: sticky failure indications
`define RES_ST_FAIL_BIT 0
`define RES_AZ_FAIL_BIT 1
`define RES_TRIM_FAIL_BIT 2
// IRQ bits
`define IRQ_RX_START_BIT 0
`define IRQ_RX_IDLE_BIT 1
`define IRQ_FAIL_BIT 2
`define IRQ_OK_BIT 3

// ****************************************
// Reset values
// ****************************************
`define CTRL_CFG_RST 3'h7
`define IRQ_MASK_RST 4'h0

// ****************************************
// Timing
// ****************************************
`define PCLK_HZ 125000000
`define BAUD 9600
`define BIT_CYCLES ((`PCLK_HZ) / (`BAUD))
`define IDLE_CHARS 4
`define POWERUP_US 100

`endif

// file: rtl/sensor_ctl_pkg.sv
// Purpose: Types shared by the sensor control logic
// Assumes: Nothing
// Notes: Constants live in sensor_ctl_consts.svh
package sensor_ctl_pkg;
    typedef enum logic [1:0] {
        OP_POWERUP,
        OP_RUN,
        OP_BUSY
    } op_state_e;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } rx_state_e;
endpackage : sensor_ctl_pkg

// file: rtl/serial_activity.sv
// Purpose: Detect valid 9600 baud characters on the shared pin
// Assumes: Pin already synchronous to pclk, idle line high (mark)
// Notes: Pulses char_ok per character with a correct stop bit
`timescale 1ns/1ns
`default_nettype none
`include "sensor_ctl_consts.svh"

module serial_activity #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rx_pin,
    output logic char_ok
);
    if (BIT_CYCLES < 4)
    begin : g_bit_check
        $error("BIT_CYCLES too small");
    end

    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

    sensor_ctl_pkg::rx_state_e state_q;
    logic [CW-1:0] cnt_q;
    logic [2:0] bit_q;
    logic rx_prev_q;

    // ****************************************
    // Character framing
    // ****************************************
    // 9600 baud framing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= sensor_ctl_pkg::RX_IDLE;
            cnt_q <= '0;
            bit_q <= 3'h0;
            char_ok <= 1'b0;
            // Low so a pin already low at reset is not read as a start bit
            rx_prev_q <= 1'b0;
        end
        else
        begin
            char_ok <= 1'b0;
            rx_prev_q <= rx_pin;
            unique case (state_q)
                sensor_ctl_pkg::RX_IDLE:
                begin
                    cnt_q <= '0;
                    // Falling edge only: a held-low control level is one failed frame
                    if (rx_prev_q && !rx_pin)
                    begin
                        state_q <= sensor_ctl_pkg::RX_START;
                    end
                end
                sensor_ctl_pkg::RX_START:
                begin
                    // Glitches shorter than half a bit are rejected
                    if (cnt_q == HALF)
                    begin
                        cnt_q <= '0;
                        bit_q <= 3'h0;
                        state_q <= rx_pin ? sensor_ctl_pkg::RX_IDLE : sensor_ctl_pkg::RX_DATA;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                sensor_ctl_pkg::RX_DATA:
                begin
                    if (cnt_q == FULL)
                    begin
                        cnt_q <= '0;
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == 3'h7)
                        begin
                            state_q <= sensor_ctl_pkg::RX_STOP;
                        end
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                sensor_ctl_pkg::RX_STOP:
                begin
                    if (cnt_q == FULL)
                    begin
                        char_ok <= rx_pin;
                        state_q <= sensor_ctl_pkg::RX_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : serial_activity
`default_nettype wire

// file: rtl/sensor_ctl.sv
// Purpose: Control pin arbitration, transmit enable and status output
// Assumes: Shared pin synchronous to pclk; firmware reports results over APB
// Notes: Firmware sequences auto-zero, self-test and trim; this block gates them
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sensor_ctl_consts.svh"

module sensor_ctl #(
    parameter int BIT_CYCLES = `BIT_CYCLES,
    parameter int IDLE_CYCLES = `BIT_CYCLES * 10 * `IDLE_CHARS,
    parameter int POWERUP_CYCLES = `POWERUP_US * (`PCLK_HZ / 1000000)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shared_pin,
    output logic tx_enable,
    output logic cal_enable,
    output logic autozero_start,
    output logic selftest_start,
    output logic status_ok,
    output logic irq
);
    if (IDLE_CYCLES < BIT_CYCLES * 10 || POWERUP_CYCLES < 1)
    begin : g_timing_check
        $error("Timing parameters out of range");
    end

    localparam int IW = $clog2(IDLE_CYCLES + 1);
    localparam int PW = $clog2(POWERUP_CYCLES + 1);

    // ****************************************
    // APB decode
    // ****************************************
    logic wr_en;
    logic rd_en;
    logic hit;

    function automatic logic is_reg(input logic [11:0] a);
        return a == `OFS_CTRL_CFG || a == `OFS_FW_CTRL || a == `OFS_RESULT ||
               a == `OFS_STATUS || a == `OFS_IRQ_STAT || a == `OFS_IRQ_MASK;
    endfunction : is_reg

    assign hit = is_reg(paddr);
    assign wr_en = psel && penable && pwrite && hit && pstrb[0];
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ****************************************
    // Serial activity and idle timeout
    // ****************************************
    logic char_ok;
    logic serial_q;
    logic [IW-1:0] idle_q;
    logic rx_start_ev;
    logic rx_idle_ev;

    serial_activity #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .rx_pin(shared_pin),
        .char_ok(char_ok)
    );

    assign rx_start_ev = char_ok && !serial_q;
    assign rx_idle_ev = serial_q && !char_ok && (idle_q == IW'(1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_q <= 1'b0;
            idle_q <= '0;
        end
        else if (char_ok)
        begin
            serial_q <= 1'b1;
            idle_q <= IW'(IDLE_CYCLES);
        end
        else if (idle_q != '0)
        begin
            idle_q <= idle_q - 1'b1;
            if (idle_q == IW'(1))
            begin
                serial_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_enable <= 1'b0;
        end
        else
        begin
            tx_enable <= char_ok || (serial_q && !rx_idle_ev);
        end
    end

    // ****************************************
    // Control pin interpretation
    // ****************************************
    logic [2:0] cfg_q;
    logic ctrl_level;
    logic ctrl_prev_q;
    logic pin_low_q;

    // A pin dropping low may be a start bit; wait a character before
    // trusting it as a released control level.
    logic [IW-1:0] low_cnt_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_cnt_q <= '0;
            pin_low_q <= 1'b1;
        end
        else if (shared_pin)
        begin
            low_cnt_q <= '0;
            pin_low_q <= 1'b0;
        end
        else if (low_cnt_q == IW'(BIT_CYCLES * 10))
        begin
            pin_low_q <= 1'b1;
        end
        else
        begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    assign ctrl_level = !pin_low_q && !serial_q && !char_ok;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_prev_q <= 1'b0;
        end
        else
        begin
            ctrl_prev_q <= ctrl_level;
        end
    end

    // ****************************************
    // Firmware control and results
    // ****************************************
    logic fw_cal_q;
    logic fw_busy_q;
    logic [2:0] result_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic fw_done;
    logic fw_fail;
    logic [3:0] ev;
    sensor_ctl_pkg::op_state_e op_q;
    logic [PW-1:0] pu_q;

    assign fw_done = wr_en && paddr == `OFS_FW_CTRL && pwdata[`FW_DONE_BIT];
    assign fw_fail = fw_done && pwdata[`FW_FAIL_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= `CTRL_CFG_RST;
            fw_cal_q <= 1'b0;
            irq_mask_q <= `IRQ_MASK_RST;
        end
        else if (wr_en)
        begin
            if (paddr == `OFS_CTRL_CFG)
            begin
                cfg_q <= pwdata[2:0];
            end
            if (paddr == `OFS_FW_CTRL)
            begin
                fw_cal_q <= pwdata[`FW_CAL_EN_BIT];
            end
            if (paddr == `OFS_IRQ_MASK)
            begin
                irq_mask_q <= pwdata[3:0];
            end
        end
    end

    logic cal_d;
    logic az_d;
    logic st_d;
    assign cal_d = fw_cal_q || (ctrl_level && cfg_q[`CFG_CAL_BIT]);
    assign az_d = (ctrl_level && !ctrl_prev_q && cfg_q[`CFG_AZ_BIT]) ||
                  (wr_en && paddr == `OFS_FW_CTRL && pwdata[`FW_AZ_GO_BIT]);
    assign st_d = (ctrl_level && !ctrl_prev_q && cfg_q[`CFG_ST_BIT]) ||
                  (wr_en && paddr == `OFS_FW_CTRL && pwdata[`FW_ST_GO_BIT]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_enable <= 1'b0;
            autozero_start <= 1'b0;
            selftest_start <= 1'b0;
        end
        else
        begin
            cal_enable <= cal_d;
            autozero_start <= az_d;
            selftest_start <= st_d;
        end
    end

    // Operating state: power-up hold, then run or busy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_q <= sensor_ctl_pkg::OP_POWERUP;
            pu_q <= PW'(POWERUP_CYCLES);
            fw_busy_q <= 1'b0;
        end
        else
        begin
            unique case (op_q)
                sensor_ctl_pkg::OP_POWERUP:
                begin
                    pu_q <= pu_q - 1'b1;
                    if (pu_q == PW'(1))
                    begin
                        op_q <= sensor_ctl_pkg::OP_RUN;
                    end
                end
                sensor_ctl_pkg::OP_RUN:
                begin
                    if (autozero_start || selftest_start ||
                        (wr_en && paddr == `OFS_FW_CTRL && pwdata[`FW_BUSY_BIT]))
                    begin
                        op_q <= sensor_ctl_pkg::OP_BUSY;
                    end
                end
                sensor_ctl_pkg::OP_BUSY:
                begin
                    if (fw_done)
                    begin
                        op_q <= sensor_ctl_pkg::OP_RUN;
                    end
                end
            endcase
            fw_busy_q <= op_q != sensor_ctl_pkg::OP_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_q <= 3'h0;
        end
        else if (fw_fail)
        begin
            result_q[`RES_ST_FAIL_BIT] <= result_q[`RES_ST_FAIL_BIT] | pwdata[`FW_ST_GO_BIT];
            result_q[`RES_AZ_FAIL_BIT] <= result_q[`RES_AZ_FAIL_BIT] | pwdata[`FW_AZ_GO_BIT];
            result_q[`RES_TRIM_FAIL_BIT] <= result_q[`RES_TRIM_FAIL_BIT] |
                                            pwdata[`FW_TRIM_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_ok <= 1'b0;
        end
        else
        begin
            // Next values too, so status falls with cal or a start pulse, not after
            status_ok <= op_q == sensor_ctl_pkg::OP_RUN && !cal_d && result_q == 3'h0 &&
                         !autozero_start && !selftest_start && !az_d && !st_d;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign ev = {fw_done && !fw_fail, fw_fail, rx_idle_ev, rx_start_ev};

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_q <= 4'h0;
        end
        else if (wr_en && paddr == `OFS_IRQ_STAT)
        begin
            irq_stat_q <= (irq_stat_q & ~pwdata[3:0]) | ev;
        end
        else
        begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `OFS_CTRL_CFG: prdata <= {29'h0, cfg_q};
                `OFS_FW_CTRL: prdata <= {28'h0, fw_busy_q, 2'h0, fw_cal_q};
                `OFS_RESULT: prdata <= {29'h0, result_q};
                `OFS_STATUS: prdata <= {26'h0, serial_q, tx_enable, status_ok,
                                        cal_enable, ctrl_level, shared_pin};
                `OFS_IRQ_STAT: prdata <= {28'h0, irq_stat_q};
                `OFS_IRQ_MASK: prdata <= {28'h0, irq_mask_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    logic unused;
    assign unused = rd_en;
endmodule : sensor_ctl
`default_nettype wire

// file: test/sensor_ctl_chk.sv
// Purpose: Port checks for sensor_ctl
// Assumes: Shared pin synchronous to pclk
// Notes: Bound to sensor_ctl below the module
`timescale 1ns/1ns
`default_nettype none
module sensor_ctl_chk #(
    parameter int BIT_CYCLES = 8,
    parameter int IDLE_CYCLES = 200,
    parameter int POWERUP_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    input wire logic shared_pin,
    input wire logic tx_enable,
    input wire logic cal_enable,
    input wire logic autozero_start,
    input wire logic selftest_start,
    input wire logic status_ok
);
    int rst_q;
    int hi_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************
    // Helper counters
    // ****************
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            rst_q <= 0;
        else if (rst_q < POWERUP_CYCLES)
            rst_q <= rst_q + 1;
    // Saturates so a long idle spell cannot wrap
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            hi_q <= 0;
        else if (!shared_pin)
            hi_q <= 0;
        else if (hi_q < 4095)
            hi_q <= hi_q + 1;
    // ****************
    // Properties
    // ****************
    property p_cal_ok; status_ok |-> !cal_enable; endproperty
    property p_st_busy; selftest_start |=> !status_ok [*2]; endproperty
    property p_az_busy; autozero_start |=> !status_ok [*2]; endproperty
    property p_pwrup; rst_q < POWERUP_CYCLES |-> !status_ok; endproperty
    property p_tx_stop; $rose(tx_enable) |-> shared_pin && $past(shared_pin); endproperty
    property p_rx_gate;
        (autozero_start || selftest_start) && tx_enable |-> $past(psel && penable && pwrite);
    endproperty
    property p_idle_min; $fell(tx_enable) |-> hi_q >= IDLE_CYCLES - 2 * BIT_CYCLES; endproperty
    // Pin is high for most of an all-ones character before its stop sample
    property p_idle_max; hi_q > IDLE_CYCLES + 11 * BIT_CYCLES |-> !tx_enable; endproperty
    property p_slverr; pslverr |-> psel && penable; endproperty
    a_cal_ok: assert property (p_cal_ok)
        else $error("status high while calibrating");
    a_st_busy: assert property (p_st_busy)
        else $error("status high during self-test");
    a_az_busy: assert property (p_az_busy)
        else $error("status high during auto-zero");
    a_pwrup: assert property (p_pwrup)
        else $error("status high during power-up");
    a_tx_stop: assert property (p_tx_stop)
        else $error("transmit enabled without valid stop bit");
    a_rx_gate: assert property (p_rx_gate)
        else $error("control pulse while receiving");
    a_idle_min: assert property (p_idle_min)
        else $error("transmit dropped before idle timeout");
    a_idle_max: assert property (p_idle_max)
        else $error("transmit held past idle timeout");
    a_slverr: assert property (p_slverr)
        else $error("slave error outside access phase");
    c_tx: cover property ($rose(tx_enable));
    c_ok: cover property ($rose(status_ok));
    c_st: cover property (selftest_start);
endmodule : sensor_ctl_chk
bind sensor_ctl sensor_ctl_chk #(
    .BIT_CYCLES(BIT_CYCLES), .IDLE_CYCLES(IDLE_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES)
) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pslverr(pslverr), .shared_pin(shared_pin), .tx_enable(tx_enable),
    .cal_enable(cal_enable), .autozero_start(autozero_start),
    .selftest_start(selftest_start), .status_ok(status_ok)
);
`default_nettype wire

// file: test/host_model.sv
// Purpose: Recorder side of the shared control and receive pin
// Assumes: Idle serial line is high
// Notes: Undriven control reads low, so low stands for released
`timescale 1ns/1ns
`default_nettype none
module host_model #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic pclk,
    output logic shared_pin
);
    initial shared_pin = 1'b0;
    task automatic set_level(input logic v);
        @(posedge pclk);
        shared_pin <= v;
    endtask : set_level
    task automatic send_char(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge pclk);
            shared_pin <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge pclk);
        end
    endtask : send_char
endmodule : host_model
`default_nettype wire

// file: test/sensor_ctl_bench.sv
// Purpose: Self-checking bench for sensor_ctl
// Assumes: Short bit, idle and power-up counts
// Notes: Scenarios run in one fixed sequence
`timescale 1ns/1ns
`default_nettype none
`include "sensor_ctl_consts.svh"
module sensor_ctl_bench;
    localparam int BC = 8;
    localparam int IC = 200;
    localparam int PC = 10;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, shared_pin, tx_enable, cal_enable;
    logic autozero_start, selftest_start, status_ok, irq, err;
    logic [31:0] rd;
    int fail_count = 0;
    int num_checks = 0;
    initial forever #4 pclk = ~pclk;
    sensor_ctl #(.BIT_CYCLES(BC), .IDLE_CYCLES(IC), .POWERUP_CYCLES(PC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shared_pin(shared_pin), .tx_enable(tx_enable), .cal_enable(cal_enable),
        .autozero_start(autozero_start), .selftest_start(selftest_start),
        .status_ok(status_ok), .irq(irq)
    );
    host_model #(.BIT_CYCLES(BC)) host (.pclk(pclk), .shared_pin(shared_pin));
    // ****************
    // Shared tasks
    // ****************
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            chk(pready, 1'b1, "bus hang");
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, ZERO, 4'h0);
        chk(rd, e, m);
    endtask : rdc
    task automatic wait_ok(input logic e);
        int n;
        n = 0;
        while (status_ok !== e && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        chk(status_ok, e, "status level");
        if (status_ok !== e)
            conclude();
    endtask : wait_ok
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        @(posedge pclk);
        chk(status_ok, 1'b0, "low at power-up");
        rdc(`OFS_CTRL_CFG, 32'h0000_0007, "cfg reset");
        rdc(`OFS_IRQ_MASK, ZERO, "mask reset");
        rdc(`OFS_RESULT, ZERO, "result reset");
        rdc(12'h020, ZERO, "unmapped data");
        chk(err, 1'b1, "unmapped error");
        apb(1'b1, `OFS_CTRL_CFG, ZERO, 4'hE);
        rdc(`OFS_CTRL_CFG, 32'h0000_0007, "write without lane 0 ignored");
        wait_ok(1'b1);
    endtask : t_regs
    task automatic t_ctrl(input logic [2:0] cfg);
        int na;
        int ns;
        na = 0;
        ns = 0;
        wr(`OFS_CTRL_CFG, {29'h0, cfg});
        host.set_level(1'b1);
        repeat (20)
        begin
            @(posedge pclk);
            na += autozero_start;
            ns += selftest_start;
        end
        chk(cal_enable, cfg[0], "cal follows pin");
        chk(na, cfg[1], "auto-zero pulses");
        chk(ns, cfg[2], "self-test pulses");
        chk(status_ok, 1'b0, "low while active");
        host.set_level(1'b0);
        repeat (12 * BC + 10) @(posedge pclk);
        chk(cal_enable, 1'b0, "low level disables");
        if (cfg[2:1] != 2'b00)
            wr(`OFS_FW_CTRL, 32'h0000_0010);
        wait_ok(1'b1);
    endtask : t_ctrl
    task automatic t_serial();
        int nc;
        nc = 0;
        wr(`OFS_CTRL_CFG, ZERO);
        wr(`OFS_IRQ_STAT, 32'h0000_000F);
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        host.set_level(1'b1);
        repeat (2 * BC) @(posedge pclk);
        host.send_char(8'h55);
        repeat (2) @(posedge pclk);
        chk(tx_enable, 1'b1, "transmit after char");
        chk(irq, 1'b1, "receive irq");
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
        wr(`OFS_IRQ_MASK, 32'h0000_0002);
        @(posedge pclk);
        chk(irq, 1'b0, "irq cleared");
        wr(`OFS_FW_CTRL, 32'h0000_0002);
        wr(`OFS_FW_CTRL, 32'h0000_0010);
        wr(`OFS_CTRL_CFG, 32'h0000_0001);
        fork
            host.send_char(8'hFF);
            repeat (10 * BC)
            begin
                @(posedge pclk);
                nc += cal_enable;
            end
        join
        chk(nc, ZERO, "pin ignored in frame");
        repeat (IC - 3 * BC) @(posedge pclk);
        chk(tx_enable, 1'b1, "transmit held in idle");
        repeat (4 * BC) @(posedge pclk);
        chk(tx_enable, 1'b0, "transmit off after idle");
        chk(cal_enable, 1'b1, "control back");
        chk(irq, 1'b1, "idle irq");
        wr(`OFS_IRQ_MASK, ZERO);
        @(posedge pclk);
        chk(irq, 1'b0, "irq masked");
        host.set_level(1'b0);
        repeat (12 * BC + 10) @(posedge pclk);
    endtask : t_serial
    task automatic t_fail();
        wr(`OFS_FW_CTRL, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(cal_enable, 1'b1, "firmware cal");
        chk(status_ok, 1'b0, "low in cal");
        wr(`OFS_FW_CTRL, ZERO);
        wait_ok(1'b1);
        wr(`OFS_FW_CTRL, 32'h0000_0004);
        @(posedge pclk);
        chk(status_ok, 1'b0, "low in self-test");
        wr(`OFS_FW_CTRL, 32'h0000_0034);
        wr(`OFS_FW_CTRL, 32'h0000_0032);
        wr(`OFS_FW_CTRL, 32'h0000_0070);
        wr(`OFS_FW_CTRL, 32'h0000_0010);
        rdc(`OFS_RESULT, 32'h0000_0007, "failures sticky");
        chk(status_ok, 1'b0, "held after failure");
        wr(`OFS_FW_CTRL, 32'h0000_0002);
        wr(`OFS_FW_CTRL, 32'h0000_0010);
        repeat (4) @(posedge pclk);
        chk(status_ok, 1'b0, "retry keeps low");
        do_reset();
        rdc(`OFS_RESULT, ZERO, "cleared by reset");
        wait_ok(1'b1);
    endtask : t_fail
    initial
    begin
        do_reset();
        t_regs();
        t_ctrl(3'b001);
        t_ctrl(3'b010);
        t_ctrl(3'b100);
        t_serial();
        t_fail();
        conclude();
    end
endmodule : sensor_ctl_bench
`default_nettype wire
